/* dps_pkg.sv */
// Constants shared by the drive protection supervisor and its loss timer.
// Assumes a 100 MHz control clock and a 4-bit word-indexed register port.
package dps_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int RAMP_TICK_NS = 1000000;
   localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;
   localparam int LOSS_UNIT_MS = 100;
   localparam logic [6:0] LOSS_UNIT_TICKS = 7'h64;

   // ----------------------------------------
   // Register indices
   // ----------------------------------------
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_STALL_LVL = 4'h1;
   localparam logic [3:0] REG_RATED = 4'h2;
   localparam logic [3:0] REG_RELAY = 4'h3;
   localparam logic [3:0] REG_INFUNC = 4'h4;
   localparam logic [3:0] REG_LOSS = 4'h5;
   localparam logic [3:0] REG_WAIT = 4'h6;
   localparam logic [3:0] REG_VMIN = 4'h7;
   localparam logic [3:0] REG_V2MIN = 4'h8;
   localparam logic [3:0] REG_IMIN = 4'h9;
   localparam logic [3:0] REG_DCLIM = 4'ha;
   localparam logic [3:0] REG_ACC = 4'hb;
   localparam logic [3:0] REG_DEC = 4'hc;
   localparam logic [3:0] REG_FCMD = 4'hd;
   localparam logic [3:0] REG_STATUS = 4'he;
   localparam logic [3:0] REG_FOUT = 4'hf;

   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   localparam logic [2:0] STALL_MASK_RST = 3'h0;
   localparam logic [1:0] PHASE_MASK_RST = 2'h3;
   localparam logic [7:0] STALL_LVL_RST = 8'h96;
   localparam logic [7:0] STALL_LVL_MIN = 8'h1e;
   localparam logic [7:0] STALL_LVL_MAX = 8'hc8;
   localparam logic [15:0] RATED_RST = 16'h0100;
   localparam logic [4:0] RELAY_RST = 5'h11;
   localparam logic [4:0] IN4_RST = 5'h03;
   localparam logic [4:0] IN5_RST = 5'h04;
   localparam logic [10:0] WAIT_RST = 11'h00a;
   localparam logic [10:0] WAIT_MIN = 11'h001;
   localparam logic [10:0] WAIT_MAX = 11'h4b0;
   localparam logic [15:0] DCLIM_RST = 16'h0300;
   localparam logic [15:0] STEP_RST = 16'h0001;

   // ----------------------------------------
   // Codes
   // ----------------------------------------
   localparam logic [4:0] FN_TRIP_NO = 5'h12;
   localparam logic [4:0] FN_TRIP_NC = 5'h13;
   localparam logic [4:0] RLY_IOL = 5'h06;
   localparam logic [4:0] RLY_STALL = 5'h07;
   localparam logic [4:0] RLY_LOST = 5'h0b;
   localparam logic [1:0] CRIT_OFF = 2'h0;
   localparam logic [1:0] CRIT_HALF = 2'h1;
   localparam logic [1:0] CRIT_MIN = 2'h2;
   localparam logic [1:0] RESP_HOLD = 2'h0;
   localparam logic [1:0] RESP_COAST = 2'h1;
   localparam logic [1:0] RESP_RAMP = 2'h2;
   localparam logic [2:0] SRC_V1 = 3'h0;
   localparam logic [2:0] SRC_V2 = 3'h1;
   localparam logic [2:0] SRC_I = 3'h2;
   localparam logic [2:0] SRC_V2I = 3'h3;
   localparam logic [2:0] SRC_COMM = 3'h4;
   localparam logic [7:0] PCT_FULL = 8'h64;

   typedef enum logic [1:0] {RS_STOP, RS_ACCEL, RS_CONST, RS_DECEL} dps_ramp_e;

endpackage

/* dps_loss_if.sv */
// Link between the supervisor and its reference loss timer.
// Assumes both ends share clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface dps_loss_if;
   logic tick;
   logic absent;
   logic [10:0] wait_ds;
   logic lost;
   modport sup (output tick, output absent, output wait_ds, input lost);
   modport tmr (input tick, input absent, input wait_ds, output lost);
endinterface
`default_nettype wire

/* dps_loss_timer.sv */
// Reference loss timer: declares loss once the reference stays absent
// for the wait time. Assumes a 1 ms tick enable from the supervisor.
`timescale 1ns/1ns
`default_nettype none
module dps_loss_timer
(
   input wire logic clk_sys,
   input wire logic nrst,
   dps_loss_if.tmr lk
);

   logic [6:0] ms_reg;
   logic [10:0] ds_reg;
   logic lost_reg;

   // ----------------------------------------
   // Absence timing
   // ----------------------------------------
   // Any return of the reference restarts the wait from zero.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst || !lk.absent)
      begin
         ms_reg <= 7'h00;
         ds_reg <= 11'h000;
      end
      else if (lk.tick && ds_reg < lk.wait_ds)
      begin
         if (ms_reg == dps_pkg::LOSS_UNIT_TICKS - 7'h01)
         begin
            ms_reg <= 7'h00;
            ds_reg <= ds_reg + 11'h001;
         end
         else
            ms_reg <= ms_reg + 7'h01;
      end
   end

   // Loss stands only while the reference stays absent.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst || !lk.absent)
         lost_reg <= 1'b0;
      else if (ds_reg >= lk.wait_ds)
         lost_reg <= 1'b1;
   end

   assign lk.lost = lost_reg;

endmodule
`default_nettype wire

/* dps_supervisor.sv */
// Drive protection supervisor: stall prevention, phase loss, external
// trips, overload reporting and reference loss, with a relay selector.
// Assumes measurements from same-clock logic and trip contacts from pins.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module dps_supervisor
#(
   parameter int RAMP_TICK_CYCLES = dps_pkg::RAMP_TICK_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [15:0] out_current,
   input wire logic [15:0] dc_link_volt,
   input wire logic [15:0] volt_in,
   input wire logic [15:0] volt2_in,
   input wire logic [15:0] current_in,
   input wire logic comm_ref_ok,
   input wire logic inv_overload_trip,
   input wire logic [1:0] trip_in_pins,
   input wire logic [2:0] out_phase_lost_pins,
   input wire logic [2:0] in_phase_lost_pins,
   output logic [15:0] freq_out,
   output logic gate_enable,
   output logic fault,
   output logic relay_out
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // True when a value sits below its minimum under the given criterion.
   function automatic logic below_min(input logic [15:0] v,
                                      input logic [15:0] m,
                                      input logic [1:0] crit);
      logic r;
      r = 1'b0;
      case (crit)
         dps_pkg::CRIT_HALF: r = v < {1'b0, m[15:1]};
         dps_pkg::CRIT_MIN: r = v < m;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Trip decision for one multi-function input and its contact level.
   function automatic logic ext_trip(input logic [4:0] fn, input logic closed);
      logic r;
      r = 1'b0;
      if (fn == dps_pkg::FN_TRIP_NO)
         r = closed;
      else if (fn == dps_pkg::FN_TRIP_NC)
         r = !closed;
      return r;
   endfunction

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [2:0] stall_enable_mask_reg;
   logic [1:0] phase_loss_enable_mask_reg;
   logic run_reg;
   logic [7:0] stall_current_level_reg;
   logic [15:0] motor_rated_current_reg;
   logic [4:0] relay_function_select_reg;
   logic [4:0] input4_function_reg;
   logic [4:0] input5_function_reg;
   logic [1:0] ref_loss_criterion_reg;
   logic [1:0] ref_loss_response_reg;
   logic [2:0] ref_source_reg;
   logic [10:0] ref_loss_wait_time_reg;
   logic [15:0] volt_input_min_reg;
   logic [15:0] volt2_input_min_reg;
   logic [15:0] current_input_min_reg;
   logic [15:0] dc_limit_reg;
   logic [15:0] accel_step_reg;
   logic [15:0] decel_step_reg;
   logic [15:0] freq_cmd_reg;
   logic [7:0] lvl_wr;
   logic [10:0] wait_wr;

   // Out-of-range writes are clamped so the limits always hold.
   assign lvl_wr = (reg_wdata[7:0] < dps_pkg::STALL_LVL_MIN) ? dps_pkg::STALL_LVL_MIN :
                   (reg_wdata[7:0] > dps_pkg::STALL_LVL_MAX) ? dps_pkg::STALL_LVL_MAX :
                   reg_wdata[7:0];
   assign wait_wr = (reg_wdata[10:0] < dps_pkg::WAIT_MIN) ? dps_pkg::WAIT_MIN :
                    (reg_wdata[10:0] > dps_pkg::WAIT_MAX) ? dps_pkg::WAIT_MAX :
                    reg_wdata[10:0];

   // Register writes.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         stall_enable_mask_reg <= dps_pkg::STALL_MASK_RST;
         phase_loss_enable_mask_reg <= dps_pkg::PHASE_MASK_RST;
         run_reg <= 1'b0;
         stall_current_level_reg <= dps_pkg::STALL_LVL_RST;
         motor_rated_current_reg <= dps_pkg::RATED_RST;
         relay_function_select_reg <= dps_pkg::RELAY_RST;
         input4_function_reg <= dps_pkg::IN4_RST;
         input5_function_reg <= dps_pkg::IN5_RST;
         ref_loss_criterion_reg <= dps_pkg::CRIT_OFF;
         ref_loss_response_reg <= dps_pkg::RESP_HOLD;
         ref_source_reg <= dps_pkg::SRC_V1;
         ref_loss_wait_time_reg <= dps_pkg::WAIT_RST;
         volt_input_min_reg <= 16'h0000;
         volt2_input_min_reg <= 16'h0000;
         current_input_min_reg <= 16'h0000;
         dc_limit_reg <= dps_pkg::DCLIM_RST;
         accel_step_reg <= dps_pkg::STEP_RST;
         decel_step_reg <= dps_pkg::STEP_RST;
         freq_cmd_reg <= 16'h0000;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            dps_pkg::REG_CFG:
            begin
               stall_enable_mask_reg <= reg_wdata[2:0];
               phase_loss_enable_mask_reg <= reg_wdata[5:4];
               run_reg <= reg_wdata[8];
            end
            dps_pkg::REG_STALL_LVL: stall_current_level_reg <= lvl_wr;
            dps_pkg::REG_RATED: motor_rated_current_reg <= reg_wdata;
            dps_pkg::REG_RELAY: relay_function_select_reg <= reg_wdata[4:0];
            dps_pkg::REG_INFUNC:
            begin
               input4_function_reg <= reg_wdata[4:0];
               input5_function_reg <= reg_wdata[12:8];
            end
            dps_pkg::REG_LOSS:
            begin
               ref_loss_criterion_reg <= reg_wdata[1:0];
               ref_loss_response_reg <= reg_wdata[5:4];
               ref_source_reg <= reg_wdata[10:8];
            end
            dps_pkg::REG_WAIT: ref_loss_wait_time_reg <= wait_wr;
            dps_pkg::REG_VMIN: volt_input_min_reg <= reg_wdata;
            dps_pkg::REG_V2MIN: volt2_input_min_reg <= reg_wdata;
            dps_pkg::REG_IMIN: current_input_min_reg <= reg_wdata;
            dps_pkg::REG_DCLIM: dc_limit_reg <= reg_wdata;
            dps_pkg::REG_ACC: accel_step_reg <= reg_wdata;
            dps_pkg::REG_DEC: decel_step_reg <= reg_wdata;
            dps_pkg::REG_FCMD: freq_cmd_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [7:0] pin_meta_reg;
   logic [7:0] pin_sync_reg;

   // Contacts and phase detectors are asynchronous to clk_sys.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         pin_meta_reg <= 8'h03;
         pin_sync_reg <= 8'h03;
      end
      else
      begin
         pin_meta_reg <= {in_phase_lost_pins, out_phase_lost_pins, trip_in_pins};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ----------------------------------------
   // Ramp tick divider
   // ----------------------------------------
   logic [31:0] div_reg;
   logic tick;

   always_ff @(posedge clk_sys)
   begin
      if (!nrst || tick)
         div_reg <= 32'h0000_0000;
      else
         div_reg <= div_reg + 32'h0000_0001;
   end

   assign tick = div_reg == 32'(RAMP_TICK_CYCLES - 1);

   // ----------------------------------------
   // Trip detection
   // ----------------------------------------
   logic [1:0] ext_hit;
   logic out_phase_hit;
   logic in_phase_hit;
   logic [4:0] in_func [2];

   assign in_func[0] = input4_function_reg;
   assign in_func[1] = input5_function_reg;

   // The same decode serves each multi-function trip input.
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_ext
         assign ext_hit[g] = ext_trip(in_func[g], pin_sync_reg[g]);
      end
   endgenerate

   assign out_phase_hit = phase_loss_enable_mask_reg[0] && |pin_sync_reg[4:2];
   assign in_phase_hit = phase_loss_enable_mask_reg[1] && |pin_sync_reg[7:5];

   // ----------------------------------------
   // Reference loss
   // ----------------------------------------
   logic ref_absent;
   logic ref_lost;
   dps_loss_if loss_lk ();

   // Serial loss is only the link going quiet; analog loss needs a criterion.
   always_comb
   begin
      ref_absent = 1'b0;
      case (ref_source_reg)
         dps_pkg::SRC_V1:
            ref_absent = below_min(volt_in, volt_input_min_reg, ref_loss_criterion_reg);
         dps_pkg::SRC_V2:
            ref_absent = below_min(volt2_in, volt2_input_min_reg, ref_loss_criterion_reg);
         dps_pkg::SRC_I:
            ref_absent = below_min(current_in, current_input_min_reg, ref_loss_criterion_reg);
         dps_pkg::SRC_V2I:
            ref_absent = below_min(volt2_in, volt2_input_min_reg, ref_loss_criterion_reg)
                      || below_min(current_in, current_input_min_reg,
                                   ref_loss_criterion_reg);
         dps_pkg::SRC_COMM: ref_absent = !comm_ref_ok;
         default: ref_absent = 1'b0;
      endcase
   end

   assign loss_lk.tick = tick;
   assign loss_lk.absent = ref_absent;
   assign loss_lk.wait_ds = ref_loss_wait_time_reg;
   assign ref_lost = loss_lk.lost;

   dps_loss_timer u_loss
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .lk(loss_lk)
   );

   // ----------------------------------------
   // Fault status, write one to clear
   // ----------------------------------------
   logic [5:0] status_reg;
   logic [5:0] status_set;
   logic [5:0] status_clr;

   assign status_set = {inv_overload_trip, 1'b0, ref_lost, in_phase_hit,
                        out_phase_hit, |ext_hit};
   assign status_clr = (reg_wr && reg_addr == dps_pkg::REG_STATUS) ? reg_wdata[5:0] : 6'h00;

   // A trip that is still present in the clearing cycle stays latched.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         status_reg <= 6'h00;
      else
         status_reg <= (status_reg & ~status_clr) | status_set;
   end

   // Output is held off while a latched external or phase trip stands.
   assign fault = |status_reg[2:0] || |ext_hit || out_phase_hit || in_phase_hit;

   // ----------------------------------------
   // Stall conditions
   // ----------------------------------------
   logic [23:0] cur_pct;
   logic [23:0] lim_pct;
   logic over_cur;
   logic over_dc;
   logic stall_now;
   logic coast;
   dps_pkg::dps_ramp_e ramp_reg;

   assign cur_pct = 24'(out_current) * 24'(dps_pkg::PCT_FULL);
   assign lim_pct = 24'(motor_rated_current_reg) * 24'(stall_current_level_reg);
   assign over_cur = cur_pct > lim_pct;
   // The limit is read straight from its register so that a rewrite acts at once.
   assign over_dc = dc_link_volt > dc_limit_reg;

   // Stall status is reported whatever the mask says.
   assign stall_now = ((ramp_reg == dps_pkg::RS_ACCEL || ramp_reg == dps_pkg::RS_CONST)
                       && over_cur) || (ramp_reg == dps_pkg::RS_DECEL && over_dc);

   assign coast = ref_lost && ref_loss_response_reg == dps_pkg::RESP_COAST;

   // ----------------------------------------
   // Frequency ramp
   // ----------------------------------------
   logic [15:0] freq_reg;
   logic [15:0] held_reg;
   logic [15:0] target;
   logic [16:0] up_sum;
   logic [16:0] dn_dif;
   logic [15:0] freq_next;
   dps_pkg::dps_ramp_e ramp_next;

   // Frequency held from when the reference went absent, used by the hold response.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         held_reg <= 16'h0000;
      else if (!ref_absent)
         held_reg <= freq_reg;
   end

   always_comb
   begin
      target = run_reg ? freq_cmd_reg : 16'h0000;
      if (ref_lost)
      begin
         case (ref_loss_response_reg)
            dps_pkg::RESP_HOLD: target = held_reg;
            dps_pkg::RESP_RAMP: target = 16'h0000;
            default: target = 16'h0000;
         endcase
      end
   end

   assign up_sum = {1'b0, freq_reg} + {1'b0, accel_step_reg};
   assign dn_dif = {1'b0, freq_reg} - {1'b0, decel_step_reg};

   // Stall handling bends the ramp, so its duration is open-ended.
   always_comb
   begin
      freq_next = freq_reg;
      ramp_next = ramp_reg;
      if (freq_reg < target)
      begin
         ramp_next = dps_pkg::RS_ACCEL;
         if (stall_enable_mask_reg[0] && over_cur)
            freq_next = dn_dif[16] ? 16'h0000 : dn_dif[15:0];
         else
            freq_next = (up_sum > {1'b0, target}) ? target : up_sum[15:0];
      end
      else if (freq_reg > target)
      begin
         ramp_next = dps_pkg::RS_DECEL;
         if (stall_enable_mask_reg[2] && over_dc)
            freq_next = freq_reg;
         else
            freq_next = (dn_dif[16] || dn_dif[15:0] < target) ? target : dn_dif[15:0];
      end
      else
      begin
         ramp_next = (target == 16'h0000) ? dps_pkg::RS_STOP : dps_pkg::RS_CONST;
         if (stall_enable_mask_reg[1] && over_cur && target != 16'h0000)
            freq_next = dn_dif[16] ? 16'h0000 : dn_dif[15:0];
      end
   end

   // Recovery after a constant-speed drop is the ordinary accel ramp.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst || coast || fault)
      begin
         freq_reg <= 16'h0000;
         ramp_reg <= dps_pkg::RS_STOP;
      end
      else if (tick)
      begin
         freq_reg <= freq_next;
         ramp_reg <= ramp_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   logic relay_reg;
   logic gate_reg;

   // Relay shows only the selected function.
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         relay_reg <= 1'b0;
      else
      begin
         case (relay_function_select_reg)
            dps_pkg::RLY_IOL: relay_reg <= inv_overload_trip;
            dps_pkg::RLY_STALL: relay_reg <= stall_now;
            dps_pkg::RLY_LOST: relay_reg <= ref_lost;
            default: relay_reg <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         gate_reg <= 1'b0;
      else
         gate_reg <= run_reg && !fault && !coast;
   end

   assign relay_out = relay_reg;
   assign gate_enable = gate_reg;
   assign freq_out = freq_reg;

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
      begin
         case (reg_addr)
            dps_pkg::REG_CFG:
               reg_rdata <= {7'h00, run_reg, 2'h0, phase_loss_enable_mask_reg,
                             1'b0, stall_enable_mask_reg};
            dps_pkg::REG_STALL_LVL: reg_rdata <= {8'h00, stall_current_level_reg};
            dps_pkg::REG_RATED: reg_rdata <= motor_rated_current_reg;
            dps_pkg::REG_RELAY: reg_rdata <= {11'h000, relay_function_select_reg};
            dps_pkg::REG_INFUNC:
               reg_rdata <= {3'h0, input5_function_reg, 3'h0, input4_function_reg};
            dps_pkg::REG_LOSS:
               reg_rdata <= {5'h00, ref_source_reg, 2'h0, ref_loss_response_reg,
                             2'h0, ref_loss_criterion_reg};
            dps_pkg::REG_WAIT: reg_rdata <= {5'h00, ref_loss_wait_time_reg};
            dps_pkg::REG_VMIN: reg_rdata <= volt_input_min_reg;
            dps_pkg::REG_V2MIN: reg_rdata <= volt2_input_min_reg;
            dps_pkg::REG_IMIN: reg_rdata <= current_input_min_reg;
            dps_pkg::REG_DCLIM: reg_rdata <= dc_limit_reg;
            dps_pkg::REG_ACC: reg_rdata <= accel_step_reg;
            dps_pkg::REG_DEC: reg_rdata <= decel_step_reg;
            dps_pkg::REG_FCMD: reg_rdata <= freq_cmd_reg;
            dps_pkg::REG_STATUS:
               reg_rdata <= {8'h00, gate_reg, relay_reg, status_reg[5], stall_now,
                             status_reg[3:0]};
            dps_pkg::REG_FOUT: reg_rdata <= freq_reg;
            default: reg_rdata <= 16'h0000;
         endcase
      end
      else
         reg_rdata <= 16'h0000;
   end

endmodule
`default_nettype wire

/* dps_monitor.sv */
// Port checker for the protection supervisor.
// Assumes one clk_sys domain with nrst active low.
`timescale 1ns/1ns
`default_nettype none
module dps_mon
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic inv_overload_trip,
   input wire logic [15:0] freq_out,
   input wire logic gate_enable,
   input wire logic fault,
   input wire logic relay_out
);
   logic [4:0] sel_reg;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Shadow of the relay select, because the registers are hidden from here.
   always_ff @(posedge clk_sys)
      if (!nrst)
         sel_reg <= 5'h11;
      else if (reg_wr && reg_addr == 4'h3)
         sel_reg <= reg_wdata[4:0];
   // ----
   // Checks
   // ----
   property p_idle; !reg_rd |=> reg_rdata == 16'h0; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_gate; fault |=> !gate_enable; endproperty
   a_gate: assert property (p_gate) else $error("gate on in fault");
   property p_fzero; fault |=> freq_out == 16'h0; endproperty
   a_fzero: assert property (p_fzero) else $error("freq in fault");
   property p_rly; $stable(sel_reg) && !(sel_reg inside {5'h6, 5'h7, 5'hb}) |-> !relay_out; endproperty
   a_rly: assert property (p_rly) else $error("relay on");
   property p_ovl; $stable(sel_reg) && sel_reg == 5'h6 && inv_overload_trip |-> ##[1:2] relay_out; endproperty
   a_ovl: assert property (p_ovl) else $error("no overload relay");
   property p_lvl; reg_rd && reg_addr == 4'h1 |=> reg_rdata inside {[16'h1e:16'hc8]}; endproperty
   a_lvl: assert property (p_lvl) else $error("level range");
   property p_fout; reg_rd && reg_addr == 4'hf |=> reg_rdata == $past(freq_out); endproperty
   a_fout: assert property (p_fout) else $error("freq read");
   property p_stat; reg_rd && reg_addr == 4'he |=> reg_rdata[7] == $past(gate_enable); endproperty
   a_stat: assert property (p_stat) else $error("status gate");
   c_trip: cover property ($rose(fault));
   c_rly: cover property ($rose(relay_out));
   c_rd: cover property (reg_rd && reg_addr == 4'he);
endmodule
bind dps_supervisor dps_mon u_mon (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .inv_overload_trip, .freq_out, .gate_enable, .fault, .relay_out);
`default_nettype wire

/* dps_plant.sv */
// Trip contacts and serial reference outside the drive.
// Assumes bench commands; everything moves on clk_sys.
`timescale 1ns/1ns
`default_nettype none
module dps_plant
(
   input wire logic clk_sys,
   input wire logic no_close,
   input wire logic nc_open,
   input wire logic ref_drop,
   output logic [1:0] trip_in_pins,
   output logic comm_ref_ok
);
   // The NC contact rests closed, so it only trips when opened.
   always_ff @(posedge clk_sys)
   begin
      trip_in_pins <= {~nc_open, no_close};
      comm_ref_ok <= ~ref_drop;
   end
endmodule
`default_nettype wire

/* test_drive_protection_supervisor.sv */
// Bench for dps_supervisor with a register model.
// Assumes dps_plant and dps_mon beside it.
`timescale 1ns/1ns
`default_nettype none
module test_drive_protection_supervisor;
   logic clk_sys = '0, nrst = '0, reg_wr = '0, reg_rd = '0, ovl = '0, no_close = '0;
   logic nc_open = '0, ref_drop = '0, comm_ref_ok, fault, gate_enable, relay_out;
   logic [3:0] reg_addr = '0, flags;
   logic [15:0] reg_wdata = '0, cur = '0, vin = '0, rv, reg_rdata, freq_out;
   logic [1:0] trip_in_pins;
   logic [5:0] ph = '0;
   int err_count = 0, tests_run = 0, n, mdl[16], al[9] = '{0, 1, 2, 3, 4, 6, 10, 11, 12};
   assign flags = {~fault, ~relay_out, relay_out, fault};
   // A 100 MHz clock.
   always #5 clk_sys = ~clk_sys;
   dps_supervisor #(.RAMP_TICK_CYCLES(10)) uut (.clk_sys, .nrst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .out_current(cur), .dc_link_volt(cur), .volt_in(vin),
      .volt2_in(vin), .current_in(vin), .comm_ref_ok, .inv_overload_trip(ovl), .trip_in_pins,
      .out_phase_lost_pins(ph[2:0]), .in_phase_lost_pins(ph[5:3]), .freq_out, .gate_enable,
      .fault, .relay_out);
   dps_plant plant (.clk_sys, .no_close, .nc_open, .ref_drop, .trip_in_pins, .comm_ref_ok);
   task automatic test_done;
      $display("Checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   // Status bits clear on write, so only plain registers enter the model.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      // An idle edge keeps the strobe from being written twice in one step.
      @(posedge clk_sys);
      if (a < 4'he)
         mdl[a] = (a != 4'h1) ? d : (d < 30) ? 30 : (d > 200) ? 200 : d;
   endtask
   task automatic rd(input logic [3:0] a);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 rv = reg_rdata;
      @(posedge clk_sys);
   endtask
   task automatic wt(input int k, input int lim);
      n = 0;
      #1;
      while (flags[k] !== 1'h1 && n < lim)
      begin
         @(posedge clk_sys);
         #1 n++;
      end
      @(posedge clk_sys);
      if (n >= lim)
      begin
         err_count++;
         test_done;
      end
   endtask
   initial
   begin
      cur = 16'($urandom(14) % 256);
      mdl = '{0: 16'h30, 1: 150, 2: 16'h100, 3: 17, 4: 16'h403, 6: 10, 10: 16'h300, default: 1};
      repeat (20) @(posedge clk_sys);
      nrst <= 1'h1;
      foreach (al[i])
      begin
         rd(4'(al[i]));
         chk("reg", 16'(mdl[al[i]]), rv);
      end
      foreach (al[i])
      begin
         wr(4'h1, (i < 2) ? 16'(i * 250) : 16'($urandom_range(30, 200)));
         rd(4'h1);
         chk("level", 16'(mdl[1]), rv);
      end
      wr(4'hf, 16'($urandom));
      rd(4'hf);
      chk("fout", 16'h0, rv);
      wr(4'h0, 16'h130);
      wr(4'hd, 16'h100);
      for (int k = 0; k < 2; k++)
      begin
         vin <= 16'($urandom);
         wr(4'h4, k ? 16'h1303 : 16'h0412);
         chk("gate", 16'h1, 16'(gate_enable));
         no_close <= (k == 0);
         nc_open <= (k == 1);
         wt(0, 6);
         #1 chk("freq", 16'h0, freq_out);
         chk("gate", 16'h0, 16'(gate_enable));
         @(posedge clk_sys);
         rd(4'he);
         chk("ext", 16'h1, {15'h0, rv[0]});
         no_close <= 1'h0;
         nc_open <= 1'h0;
         wr(4'h4, 16'h0403);
         repeat (4) @(posedge clk_sys);
         wr(4'he, 16'h3f);
         wt(3, 8);
      end
      for (int k = 0; k < 2; k++)
      begin
         ph <= 6'h1 << (3 * k + $urandom_range(0, 2));
         wt(0, 6);
         rd(4'he);
         chk("phase", 16'(k + 1), {14'h0, rv[2:1]});
         ph <= 6'h0;
         repeat (4) @(posedge clk_sys);
         wr(4'he, 16'h3f);
         wt(3, 8);
      end
      wr(4'h1, 16'h1e);
      wr(4'h3, 16'h7);
      cur <= 16'hff;
      wt(1, 40);
      cur <= 16'h0;
      wt(2, 40);
      wr(4'h3, 16'h6);
      ovl <= 1'h1;
      wt(1, 6);
      ovl <= 1'h0;
      wr(4'he, 16'h3f);
      wr(4'h6, 16'h1);
      wr(4'h5, 16'h401);
      wr(4'h3, 16'hb);
      ref_drop <= 1'h1;
      wt(1, 1100);
      chk("wait", 16'h1, 16'(n > 950));
      ref_drop <= 1'h0;
      wt(2, 8);
      test_done;
   end
endmodule
`default_nettype wire
